// >>> verilog/ssr_top.sv
// receive path of a synchronous serial port, master and slave clocking
// assumes an AXI4-Lite master on clk_sys and a serial peer on the pins
module ssr_top (
   input  wire logic                      clk_sys,
   input  wire logic                      srst,
   input  wire logic [ssr_pkg::ADDR_W-1:0] s_axi_awaddr,
   input  wire logic                      s_axi_awvalid,
   output logic                           s_axi_awready,
   input  wire logic [31:0]               s_axi_wdata,
   input  wire logic [3:0]                s_axi_wstrb,
   input  wire logic                      s_axi_wvalid,
   output logic                           s_axi_wready,
   output logic [1:0]                     s_axi_bresp,
   output logic                           s_axi_bvalid,
   input  wire logic                      s_axi_bready,
   input  wire logic [ssr_pkg::ADDR_W-1:0] s_axi_araddr,
   input  wire logic                      s_axi_arvalid,
   output logic                           s_axi_arready,
   output logic [31:0]                    s_axi_rdata,
   output logic [1:0]                     s_axi_rresp,
   output logic                           s_axi_rvalid,
   input  wire logic                      s_axi_rready,
   input  wire logic                      serial_data_pin_i,
   input  wire logic                      serial_clock_pin_i,
   output logic                           serial_clock_pin_o,
   output logic                           serial_clock_pin_oe,
   input  wire logic                      sleep_mode,
   output logic                           rx_irq,
   output logic                           irq_vector,
   output logic                           wake_req
);
   import ssr_pkg::*;

   // ****************************************
   // configuration registers
   // ****************************************
   logic        port_en_q, nine_bit_q, single_q, cont_q, overrun_q;
   logic        clk_src_q, sync_q, hi_speed_q, sckp_q, wide_div_q;
   logic        glob_ie_q, peri_ie_q, rx_ie_q;
   logic [7:0]  div_lo_q, div_hi_q;
   logic        aw_got_q, w_got_q;
   logic [5:0]  awaddr_q;
   logic [7:0]  wbyte_q;
   logic        wlane_q;
   logic        wr_fire, rd_fire, rd_pop;
   logic        wr_hit;
   logic [31:0] rd_word;
   logic        rd_hit;

   ssr_fifo_if fif ();

   assign s_axi_awready = !aw_got_q && !s_axi_bvalid;
   assign s_axi_wready  = !w_got_q && !s_axi_bvalid;
   assign s_axi_arready = !s_axi_rvalid;
   assign wr_fire       = aw_got_q && w_got_q && !s_axi_bvalid;
   assign rd_fire       = s_axi_arvalid && s_axi_arready;
   // reading the data register advances the store
   assign rd_pop        = rd_fire && s_axi_araddr == OFS_RX_DATA;

   always_comb
   begin
      wr_hit = 1'b1;
      unique case (awaddr_q)
         OFS_RX_STAT, OFS_RX_DATA, OFS_TX_STAT, OFS_BAUD_CTL,
         OFS_DIV_LO, OFS_DIV_HI, OFS_CORE_INT, OFS_IRQ_EN, OFS_IRQ_FLG: wr_hit = 1'b1;
         default: wr_hit = 1'b0;
      endcase
   end

   // ****************************************
   // axi write channel
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         aw_got_q     <= 1'b0;
         w_got_q      <= 1'b0;
         awaddr_q     <= 6'h00;
         wbyte_q      <= 8'h00;
         wlane_q      <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= RESP_OK;
      end
      else
      begin
         if (s_axi_awvalid && s_axi_awready)
         begin
            aw_got_q <= 1'b1;
            awaddr_q <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready)
         begin
            w_got_q <= 1'b1;
            wbyte_q <= s_axi_wdata[7:0];
            wlane_q <= s_axi_wstrb[0];
         end
         if (wr_fire)
         begin
            aw_got_q     <= 1'b0;
            w_got_q      <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OK : RESP_ERR;
         end
         else if (s_axi_bready)
         begin
            s_axi_bvalid <= 1'b0;
         end
      end
   end

   // ****************************************
   // receiver datapath signals
   // ****************************************
   logic        master, slave, master_run, slave_run, rx_on;
   logic        data_s, sck_s, sck_prev_q;
   logic [15:0] div_n, cnt_q;
   logic        tick, phase_q, m_trail, s_trail, sample;
   logic [3:0]  nbits, bit_cnt_q;
   logic [8:0]  sr_q, char_d;
   logic        last_bit, done, full, single_done;

   // master only when sync and clock source select are set
   assign master     = port_en_q && sync_q && clk_src_q;
   // slave takes the clock from outside when clock source is clear
   assign slave      = port_en_q && sync_q && !clk_src_q;
   // continuous wins; single covers one character
   assign master_run = master && (cont_q || single_q) && !overrun_q;
   // slave runs regardless of either receive enable
   assign slave_run  = slave && !overrun_q;
   assign rx_on      = master_run || slave_run;
   assign div_n      = wide_div_q ? {div_hi_q, div_lo_q} : {8'h00, div_lo_q};
   assign tick       = cnt_q == div_n;
   assign m_trail    = master_run && tick && phase_q;
   // trailing edge of the external clock, polarity by sckp
   assign s_trail    = slave_run && (sckp_q ? (!sck_prev_q && sck_s)
                                            : (sck_prev_q && !sck_s));
   // one data bit per trailing edge
   assign sample     = master ? m_trail : s_trail;
   // nine bits per character in nine-bit mode
   assign nbits      = nine_bit_q ? BITS_9 : BITS_8;
   assign last_bit   = bit_cnt_q == nbits - 4'h1;
   assign done       = sample && last_bit;
   assign full       = fif.count == FIFO_FULL;
   assign single_done = master && done && single_q;

   always_comb
   begin
      char_d = sr_q;
      // first sampled bit lands in bit zero
      char_d[bit_cnt_q] = data_s;
      if (!nine_bit_q)
      begin
         char_d[8] = 1'b0;
      end
   end

   ssr_sync2 u_sync_data (
      .clk_sys (clk_sys),
      .srst    (srst),
      .din     (serial_data_pin_i),
      .dout    (data_s)
   );

   ssr_sync2 u_sync_clk (
      .clk_sys (clk_sys),
      .srst    (srst),
      .din     (serial_clock_pin_i),
      .dout    (sck_s)
   );

   // ****************************************
   // control registers
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         port_en_q  <= 1'b0;
         nine_bit_q <= 1'b0;
         single_q   <= 1'b0;
         cont_q     <= 1'b0;
         clk_src_q  <= 1'b0;
         sync_q     <= 1'b0;
         hi_speed_q <= 1'b0;
         sckp_q     <= 1'b0;
         wide_div_q <= 1'b0;
         glob_ie_q  <= 1'b0;
         peri_ie_q  <= 1'b0;
         rx_ie_q    <= 1'b0;
         div_lo_q <= REG_RST;
         div_hi_q <= REG_RST;
      end
      else
      begin
         // single enable clears itself at the end of a master-mode character
         if (single_done)
         begin
            single_q <= 1'b0;
         end
         if (wr_fire && wlane_q)
         begin
            unique case (awaddr_q)
               OFS_RX_STAT:
               begin
                  port_en_q  <= wbyte_q[B_PORT_EN];
                  nine_bit_q <= wbyte_q[B_NINE_EN];
                  single_q   <= wbyte_q[B_SINGLE];
                  cont_q     <= wbyte_q[B_CONT];
               end
               OFS_TX_STAT:
               begin
                  clk_src_q  <= wbyte_q[B_CLK_SRC];
                  sync_q     <= wbyte_q[B_SYNC];
                  hi_speed_q <= wbyte_q[B_HI_SPEED];
               end
               OFS_BAUD_CTL:
               begin
                  sckp_q     <= wbyte_q[B_SCKP];
                  wide_div_q <= wbyte_q[B_WIDE_DIV];
               end
               OFS_DIV_LO:   div_lo_q <= wbyte_q;
               OFS_DIV_HI:   div_hi_q <= wbyte_q;
               OFS_CORE_INT:
               begin
                  glob_ie_q <= wbyte_q[B_GLOB_IE];
                  peri_ie_q <= wbyte_q[B_PERI_IE];
               end
               OFS_IRQ_EN:   rx_ie_q <= wbyte_q[B_RX_IE];
               default:      ;
            endcase
         end
      end
   end

   // ****************************************
   // overrun flag
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         overrun_q <= 1'b0;
      end
      else if (done && full)
      begin
         // set wins over any clear in the same cycle
         overrun_q <= 1'b1;
      end
      else if (!port_en_q || (!cont_q && !(master && single_q)))
      begin
         // port off, or continuous cleared without master single enable, ends the overrun
         overrun_q <= 1'b0;
      end
      else if (rd_pop && master && single_q && !cont_q)
      begin
         overrun_q <= 1'b0;
      end
   end

   // ****************************************
   // clock generation and shifting
   // ****************************************
   always_ff @(posedge clk_sys)
   begin
      if (srst || !master_run)
      begin
         // clearing continuous mid-character with single clear stops the clock at once
         cnt_q   <= 16'h0000;
         phase_q <= 1'b0;
      end
      else if (tick)
      begin
         cnt_q   <= 16'h0000;
         phase_q <= !phase_q;
      end
      else
      begin
         cnt_q <= cnt_q + 16'h0001;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         sck_prev_q <= 1'b0;
      end
      else
      begin
         sck_prev_q <= sck_s;
      end
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst || !rx_on)
      begin
         // a partial character is thrown away
         bit_cnt_q <= 4'h0;
         sr_q      <= 9'h000;
      end
      else if (done)
      begin
         bit_cnt_q <= 4'h0;
         sr_q      <= 9'h000;
      end
      else if (sample)
      begin
         bit_cnt_q <= bit_cnt_q + 4'h1;
         sr_q      <= char_d;
      end
   end

   // completed character enters the store unless full
   assign fif.push  = done && !full;
   assign fif.wdata = char_d;
   assign fif.pop   = rd_pop;
   // clearing the port enable resets the receiver
   assign fif.flush = !port_en_q;

   ssr_fifo u_fifo (
      .clk_sys (clk_sys),
      .srst    (srst),
      .fif     (fif)
   );

   // ****************************************
   // pins and requests
   // ****************************************
   assign serial_clock_pin_oe = master;
   assign serial_clock_pin_o  = phase_q ^ sckp_q;
   // flag while characters wait; request gated by enable
   assign rx_irq     = (fif.count != 2'h0) && rx_ie_q;
   // wake needs only the enable; vector needs global too
   assign wake_req   = sleep_mode && rx_irq;
   assign irq_vector = rx_irq && glob_ie_q && peri_ie_q;

   // ****************************************
   // axi read channel
   // ****************************************
   always_comb
   begin
      rd_word = 32'h0000_0000;
      rd_hit  = 1'b1;
      unique case (s_axi_araddr)
         // ninth bit and error flags in one status read
         OFS_RX_STAT: rd_word[7:0] = {port_en_q, nine_bit_q, single_q, cont_q, 1'b0,
                                      1'b0, overrun_q, fif.head[8]};
         OFS_RX_DATA: rd_word[7:0] = fif.head[7:0];
         OFS_TX_STAT: rd_word[7:0] = {clk_src_q, 2'h0, sync_q, 1'b0, hi_speed_q,
                                      1'b1, 1'b0};
         OFS_BAUD_CTL: rd_word[7:0] = {1'b0, !rx_on || bit_cnt_q == 4'h0, 1'b0,
                                       sckp_q, wide_div_q, 3'h0};
         OFS_DIV_LO:   rd_word[7:0] = div_lo_q;
         OFS_DIV_HI:   rd_word[7:0] = div_hi_q;
         OFS_CORE_INT: rd_word[7:0] = {glob_ie_q, peri_ie_q, 6'h00};
         OFS_IRQ_EN:   rd_word[B_RX_IE] = rx_ie_q;
         OFS_IRQ_FLG:  rd_word[B_RX_FLAG] = fif.count != 2'h0;
         default:      rd_hit = 1'b0;
      endcase
   end

   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         s_axi_rvalid <= 1'b0;
         s_axi_rdata  <= 32'h0000_0000;
         s_axi_rresp  <= RESP_OK;
      end
      else if (rd_fire)
      begin
         s_axi_rvalid <= 1'b1;
         s_axi_rdata  <= rd_word;
         s_axi_rresp  <= rd_hit ? RESP_OK : RESP_ERR;
      end
      else if (s_axi_rready)
      begin
         s_axi_rvalid <= 1'b0;
      end
   end

   // ****************************************
   // assertions
   // ****************************************
   default clocking cb @(posedge clk_sys); endclocking
   default disable iff (srst);

   sequence s_full_done;
      done && full && port_en_q;
   endsequence
   sequence s_port_off;
      !port_en_q ##1 !port_en_q;
   endsequence
   sequence s_sleep_done;
      fif.push && rx_ie_q && !wr_fire && sleep_mode ##1 sleep_mode;
   endsequence

   a_push_flags: assert property (fif.push |=> fif.count != 2'h0)
      else $error("store empty after a character");
   a_irq_gate: assert property (fif.push && rx_ie_q && !wr_fire |=> rx_irq)
      else $error("no request after a character");
   a_single_clear: assert property (single_done && !wr_fire |=> !single_q)
      else $error("single enable stayed set");
   a_overrun_keep: assert property (s_full_done |=> overrun_q && full)
      else $error("overrun not flagged or data lost");
   a_overrun_block: assert property (overrun_q |-> !fif.push && !master_run)
      else $error("reception during overrun");
   a_port_reset: assert property (s_port_off |-> !overrun_q && fif.count == 2'h0)
      else $error("port disable left state");
   a_nine_count: assert property (done |-> bit_cnt_q == (nine_bit_q ? 4'h8 : 4'h7))
      else $error("wrong character length");
   a_lsb_first: assert property (sample && bit_cnt_q == 4'h0 && !done
                                 |=> sr_q[0] == $past(data_s))
      else $error("first bit not in bit zero");
   a_wake_sleep: assert property (s_sleep_done |-> wake_req)
      else $error("no wake on sleep completion");
   a_slave_clock: assert property (slave |-> !serial_clock_pin_oe)
      else $error("slave drives clock pin");
   a_resp_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("write response dropped");
endmodule : ssr_top

// >>> inc/ssr_pkg.sv
// constants, register map and field layout of the synchronous serial receiver
// assumes a 125 MHz system clock and AXI4-Lite register access
// Notes on behaviour
// - nine-bit mode shifts nine bits per character
// - ninth-bit flag shows oldest unread character's bit
// - character done sets flag; enable gates request
// - status shows ninth bit and error flags
// - overrun cleared by continuous or port enable clear; with master single enable set, continuous clear holds it until a data read
// - slave receives like master, three exceptions
// - slave treats continuous receive as always on
// - slave ignores single-receive enable
// - slave receives during sleep on external clock
// - sleep completion wakes; vectors only with global enable
// - single enable one character; continuous wins, runs
// - sample on trailing clock edge, then FIFO
// - two-deep FIFO; third character sets overrun, blocks
// - one bit per clock, data stable at trailing
package ssr_pkg;
   // ****************************************
   // register map
   // ****************************************
   localparam int unsigned ADDR_W       = 6;
   localparam logic [5:0]  OFS_RX_STAT  = 6'h00;
   localparam logic [5:0]  OFS_RX_DATA  = 6'h04;
   localparam logic [5:0]  OFS_TX_STAT  = 6'h08;
   localparam logic [5:0]  OFS_BAUD_CTL = 6'h0C;
   localparam logic [5:0]  OFS_DIV_LO   = 6'h10;
   localparam logic [5:0]  OFS_DIV_HI   = 6'h14;
   localparam logic [5:0]  OFS_CORE_INT = 6'h18;
   localparam logic [5:0]  OFS_IRQ_EN   = 6'h1C;
   localparam logic [5:0]  OFS_IRQ_FLG  = 6'h20;
   // ****************************************
   // field positions
   // ****************************************
   localparam int unsigned B_PORT_EN   = 7;
   localparam int unsigned B_NINE_EN   = 6;
   localparam int unsigned B_SINGLE    = 5;
   localparam int unsigned B_CONT      = 4;
   localparam int unsigned B_FRAME_ERR = 2;
   localparam int unsigned B_OVERRUN   = 1;
   localparam int unsigned B_NINTH     = 0;
   localparam int unsigned B_CLK_SRC   = 7;
   localparam int unsigned B_SYNC      = 4;
   localparam int unsigned B_HI_SPEED  = 2;
   localparam int unsigned B_RCIDL     = 6;
   localparam int unsigned B_SCKP      = 4;
   localparam int unsigned B_WIDE_DIV  = 3;
   localparam int unsigned B_GLOB_IE   = 7;
   localparam int unsigned B_PERI_IE   = 6;
   localparam int unsigned B_RX_IE     = 5;
   localparam int unsigned B_RX_FLAG   = 5;
   // ****************************************
   // reset values and misc
   // ****************************************
   localparam logic [7:0] REG_RST   = 8'h00;
   localparam logic [1:0] RESP_OK   = 2'h0;
   localparam logic [1:0] RESP_ERR  = 2'h2;
   localparam logic [3:0] BITS_8    = 4'h8;
   localparam logic [3:0] BITS_9    = 4'h9;
   localparam logic [1:0] FIFO_FULL = 2'h2;
   localparam int unsigned CHAR_W   = 9;
endpackage : ssr_pkg

// >>> inc/ssr_fifo_if.sv
// signals between the receiver control and its two-character store
// assumes both ends run on clk_sys
interface ssr_fifo_if;
   logic       push;
   logic [8:0] wdata;
   logic       pop;
   logic       flush;
   logic [8:0] head;
   logic [1:0] count;
   modport ctrl (output push, output wdata, output pop, output flush,
                 input head, input count);
   modport mem  (input push, input wdata, input pop, input flush,
                 output head, output count);
endinterface : ssr_fifo_if

// >>> verilog/ssr_sync2.sv
// two-flop synchroniser for one pin input
// assumes the input is asynchronous to clk_sys
module ssr_sync2 (
   input  wire logic clk_sys,
   input  wire logic srst,
   input  wire logic din,
   output logic      dout
);
   logic meta_q;
   always_ff @(posedge clk_sys)
   begin
      if (srst)
      begin
         meta_q <= 1'b0;
         dout   <= 1'b0;
      end
      else
      begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : ssr_sync2

// >>> verilog/ssr_fifo.sv
// two-character receive store; the oldest character sits in a register
// assumes push is never given while the store is full
module ssr_fifo (
   input  wire logic clk_sys,
   input  wire logic srst,
   ssr_fifo_if.mem   fif
);
   import ssr_pkg::*;
   logic [8:0] tail_q;
   logic [1:0] count_q;
   logic       do_pop;
   assign do_pop    = fif.pop && (count_q != 2'h0);
   assign fif.count = count_q;
   always_ff @(posedge clk_sys)
   begin
      if (srst || fif.flush)
      begin
         count_q  <= 2'h0;
         fif.head <= 9'h000;
         tail_q   <= 9'h000;
      end
      else
      begin
         // head is the output register, so the reader sees no mux delay
         if (do_pop)
         begin
            fif.head <= (count_q == FIFO_FULL) ? tail_q : fif.wdata;
         end
         else if (fif.push && count_q == 2'h0)
         begin
            fif.head <= fif.wdata;
         end
         if (fif.push && ((count_q == 2'h1 && !do_pop) || count_q == FIFO_FULL))
         begin
            tail_q <= fif.wdata;
         end
         if (fif.push && !do_pop)
         begin
            count_q <= count_q + 2'h1;
         end
         else if (!fif.push && do_pop)
         begin
            count_q <= count_q - 2'h1;
         end
      end
   end
endmodule : ssr_fifo

// >>> bench/ssr_peer.sv
// serial peer model: clock slave to a master device, clock master to a slave one
// assumes sckp clear, so the clock idles low and its trailing edge falls
module ssr_peer (
   input  wire logic       ck_wire,
   input  wire logic       dev_oe,
   input  wire logic [8:0] word,
   input  wire logic [3:0] nbits,
   output logic            ck_drv,
   output logic            dat
);
   timeunit 1ns;
   timeprecision 100ps;
   int idx = 0;
   initial ck_drv = 1'b0;
   initial dat = 1'b1;
   // ****************************************
   // clock slave role
   // ****************************************
   always @(posedge ck_wire)
   begin
      if (dev_oe === 1'b1)
      begin
         dat = word[idx];
         idx = (idx + 1 == int'(nbits)) ? 0 : idx + 1;
      end
   end
   // hold time over: never leave the last bit standing
   always @(negedge ck_wire)
   begin
      if (dev_oe === 1'b1 && idx == 0)
      begin
         #24;
         if (!ck_wire)
            dat = ~dat;
      end
   end
   // ****************************************
   // clock master role; clock still between frames
   // ****************************************
   task automatic send(input logic [8:0] w, input int n);
      for (int i = 0; i < n; i++)
      begin
         dat = w[i];
         ck_drv = 1'b1;
         #62.5;
         ck_drv = 1'b0;
         #62.5;
      end
      dat = ~dat;
   endtask : send
endmodule : ssr_peer

// >>> bench/tb_top.sv
// self-checking bench for the synchronous serial receiver
// assumes the offsets of ssr_pkg and the peer model ssr_peer
module tb_top;
   timeunit 1ns;
   timeprecision 100ps;
   import ssr_pkg::*;
   logic        clk_sys = 1'b0, srst = 1'b1, sleep_mode = 1'b0;
   logic [5:0]  awaddr = '0, araddr = '0;
   logic [31:0] wdata = '0, rdata;
   logic        awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
   logic        awready, wready, bvalid, arready, rvalid, ck_o, ck_oe, ck_drv, ck_wire, dat;
   logic        rx_irq, irq_vector, wake_req;
   logic [1:0]  bresp, rresp;
   logic [8:0]  word = '0;
   logic [3:0]  nbits = 4'h8;
   int          bad_count = 0, checks_done = 0;
   assign ck_wire = ck_oe ? ck_o : ck_drv;
   always #4 clk_sys = ~clk_sys;
   ssr_top DUT (.clk_sys(clk_sys), .srst(srst), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
      .s_axi_rready(rready), .serial_data_pin_i(dat), .serial_clock_pin_i(ck_wire),
      .serial_clock_pin_o(ck_o), .serial_clock_pin_oe(ck_oe), .sleep_mode(sleep_mode),
      .rx_irq(rx_irq), .irq_vector(irq_vector), .wake_req(wake_req));
   ssr_peer peer (.ck_wire(ck_wire), .dev_oe(ck_oe), .word(word), .nbits(nbits),
      .ck_drv(ck_drv), .dat(dat));
   // ****************************************
   // tasks
   // ****************************************
   task automatic end_sim;
      if (bad_count == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : end_sim
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         bad_count++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   task automatic hang;
      bad_count++;
      end_sim();
   endtask : hang
   // handshakes judged at the falling edge, i.e. as the next rising edge sees them
   task automatic wr(input logic [5:0] a, input logic [7:0] d);
      logic ta, tw, tb;
      @(posedge clk_sys);
      awaddr <= a;
      wdata <= {24'h000000, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (int n = 0; n < 200; n++)
      begin
         @(negedge clk_sys);
         ta = awvalid && awready;
         tw = wvalid && wready;
         tb = bvalid;
         @(posedge clk_sys);
         if (ta)
            awvalid <= 1'b0;
         if (tw)
            wvalid <= 1'b0;
         if (tb)
         begin
            bready <= 1'b0;
            return;
         end
      end
      hang();
   endtask : wr
   task automatic rd(input logic [5:0] a, output logic [31:0] d, output logic [1:0] r);
      logic ta, tr;
      @(posedge clk_sys);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (int n = 0; n < 200; n++)
      begin
         @(negedge clk_sys);
         ta = arvalid && arready;
         tr = rvalid;
         d = rdata;
         r = rresp;
         @(posedge clk_sys);
         if (ta)
            arvalid <= 1'b0;
         if (tr)
         begin
            rready <= 1'b0;
            return;
         end
      end
      hang();
   endtask : rd
   task automatic wait_irq(input logic lvl);
      for (int n = 0; n < 3000; n++)
      begin
         @(negedge clk_sys);
         if (rx_irq === lvl)
            return;
      end
      hang();
   endtask : wait_irq
   // ****************************************
   // main sequence
   // ****************************************
   initial
   begin
      logic [31:0] d;
      logic [1:0]  r;
      logic [8:0]  w;
      logic        n9;
      void'($urandom(32'h9EF35EAE));
      repeat (12) @(posedge clk_sys);
      srst <= 1'b0;
      // reset values; one step past the map is refused
      for (int i = 0; i < 10; i++)
      begin
         rd(6'(i * 4), d, r);
         chk({30'h0, r}, (i == 9) ? 32'(RESP_ERR) : 32'(RESP_OK));
         if (i != 1)
            chk(d & 32'hFFFFFFBF, (i == 2) ? 32'h02 : 32'h00);
      end
      wr(6'h24, 8'h00);
      chk({30'h0, bresp}, 32'(RESP_ERR));
      wr(OFS_DIV_LO, 8'h03);
      chk({30'h0, bresp}, 32'(RESP_OK));
      wr(OFS_DIV_HI, 8'h00);
      wr(OFS_BAUD_CTL, 8'h08);
      wr(OFS_TX_STAT, 8'h90);
      wr(OFS_IRQ_EN, 8'h20);
      wr(OFS_CORE_INT, 8'hC0);
      // single-character master receptions, eight then nine bits
      for (int k = 0; k < 6; k++)
      begin
         w = 9'($urandom);
         n9 = (k >= 3);
         word <= w;
         nbits <= n9 ? 4'h9 : 4'h8;
         wr(OFS_RX_STAT, n9 ? 8'hE0 : 8'hA0);
         wait_irq(1'b1);
         chk({31'h0, irq_vector}, 32'h1);
         rd(OFS_RX_STAT, d, r);
         chk(d, {24'h0, 1'b1, n9, 5'h00, n9 & w[8]});
         rd(OFS_RX_DATA, d, r);
         chk(d, {24'h0, w[7:0]});
         chk({31'h0, rx_irq}, 32'h0);
      end
      // continuous master reception into overrun
      w = 9'($urandom);
      word <= w;
      nbits <= 4'h8;
      wr(OFS_RX_STAT, 8'h90);
      d = '0;
      for (int n = 0; n < 150 && !d[1]; n++)
         rd(OFS_RX_STAT, d, r);
      chk(d, 32'h92);
      wr(OFS_IRQ_EN, 8'h00);
      chk({31'h0, rx_irq}, 32'h0);
      rd(OFS_IRQ_FLG, d, r);
      chk(d, 32'h20);
      wr(OFS_RX_STAT, 8'h80);
      rd(OFS_RX_STAT, d, r);
      chk(d, 32'h80);
      for (int i = 0; i < 2; i++)
      begin
         rd(OFS_RX_DATA, d, r);
         chk(d, {24'h0, w[7:0]});
      end
      // slave in sleep, single enable set and continuous clear
      wr(OFS_TX_STAT, 8'h10);
      wr(OFS_IRQ_EN, 8'h20);
      wr(OFS_CORE_INT, 8'h00);
      sleep_mode <= 1'b1;
      wr(OFS_RX_STAT, 8'hA0);
      chk({31'h0, ck_oe}, 32'h0);
      w = 9'($urandom);
      peer.send(w, 8);
      wait_irq(1'b1);
      chk({30'h0, wake_req, irq_vector}, 32'h2);
      rd(OFS_RX_DATA, d, r);
      chk(d, {24'h0, w[7:0]});
      // slave overrun, cleared by disabling the port
      wr(OFS_RX_STAT, 8'h90);
      for (int i = 0; i < 3; i++)
         peer.send(w, 8);
      repeat (10) @(posedge clk_sys);
      rd(OFS_RX_STAT, d, r);
      chk(d, 32'h92);
      wr(OFS_RX_STAT, 8'h00);
      rd(OFS_RX_STAT, d, r);
      chk({d[30:0], rx_irq}, 32'h0);
      end_sim();
   end
endmodule : tb_top
